// [dv/acp_monitor.sv]
// acp_monitor: protocol checks on the serial control link
// assumes the carrier's signals and the host clock domain as inputs
`timescale 1ns/1ns
module acp_monitor
  import acp_pkg::*;
(
  input  wire logic I_REF_CLK,               // host clock
  input  wire logic I_RSTN,                  // sync reset, active low
  input  wire logic sclk,                    // serial clock
  input  wire logic host_mosi,               // 3-wire data
  input  wire logic dev_sda_o,               // device drive value
  input  wire logic dev_sda_oe,              // device drive enable
  input  wire logic latch_or_address_select, // chip select
  input  wire logic format_select,           // strap
  input  wire logic serial_data_line         // resolved line
);
  // ****************************************
  // frame bookkeeping
  // ****************************************
  logic       sda_q;
  logic       sclk_q;
  logic       oe_q;
  logic [4:0] rise_cnt;  // clock rises since the last start
  logic [2:0] ack_cnt;   // acknowledges since the last start
  logic       start_seen;
  assign start_seen = !format_select && sclk && sclk_q && sda_q &&
                      !serial_data_line;
  // counters saturate so a stuck clock cannot wrap them into a false pass
  always_ff @(posedge I_REF_CLK) begin
    sda_q  <= serial_data_line;
    sclk_q <= sclk;
    oe_q   <= dev_sda_oe;
    if (!I_RSTN || start_seen) begin
      rise_cnt <= 5'h00;
      ack_cnt  <= 3'h0;
    end else begin
      if (sclk && !sclk_q && rise_cnt != 5'h1f)
        rise_cnt <= rise_cnt + 5'h01;
      if (dev_sda_oe && !oe_q && ack_cnt != 3'h7)
        ack_cnt <= ack_cnt + 3'h1;
    end
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  sequence s_start;
    !format_select && sclk && $past(sclk) && $fell(serial_data_line);
  endsequence
  sequence s_stop;
    !format_select && sclk && $past(sclk) && $rose(serial_data_line);
  endsequence
  // ****************************************
  // checks
  // ****************************************
  quiet_in_3w_a: assert property (format_select |-> !dev_sda_oe)
    else $error("device drives data in 3-wire format");
  ack_pulls_low_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drive is not low");
  ack_clock_low_a: assert property ($rose(dev_sda_oe) |-> !sclk)
    else $error("acknowledge began with clock high");
  ack_hold_a: assert property (dev_sda_oe && sclk |=> dev_sda_oe)
    else $error("acknowledge dropped while clock high");
  ack_length_a: assert property ($rose(dev_sda_oe) |->
    dev_sda_oe[*6] ##[1:14] !dev_sda_oe)
    else $error("acknowledge pulse length wrong");
  ack_place_a: assert property ($rose(dev_sda_oe) |->
    rise_cnt == 5'h08 || rise_cnt == 5'h11 || rise_cnt == 5'h1a)
    else $error("acknowledge not after a whole byte");
  ack_count_a: assert property (ack_cnt <= 3'h3)
    else $error("more than three acknowledges in a frame");
  start_no_ack_a: assert property (s_start |-> !dev_sda_oe[*8])
    else $error("device drove data right after a start");
  stop_idle_a: assert property (s_stop |=> !dev_sda_oe[*8])
    else $error("device drove data after a stop");
  mosi_stable_a: assert property (format_select &&
    !latch_or_address_select && sclk && !$past(sclk) |-> $stable(host_mosi))
    else $error("3-wire data moved at the sampling edge");
endmodule

// [dv/acp_tb_top.sv]
// audio_codec_control_port_tb_top: both link ends joined by the carrier
// assumes the host end makes the link clock; bench drives Avalon-MM only
`timescale 1ns/1ns
module audio_codec_control_port_tb_top
  import acp_pkg::*;
;
  // ****************************************
  // harness
  // ****************************************
  logic        ref_clk = 1'b0;    // 250 MHz
  logic        rstn = 1'b0;       // sync reset, active low
  logic [3:0]  av_addr = 4'h0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        act;
  logic        aud_oe;
  logic        wr_vld;
  logic [6:0]  wr_addr;
  logic [8:0]  wr_data;
  logic [6:0]  cap_addr;
  logic [8:0]  cap_data;
  logic [26:0] wire_bits;         // bits seen on the wire in a frame
  int          wire_n = 0;
  logic        smp_wait;          // waitrequest as seen at the edge
  logic [31:0] smp_rdata;         // read data as seen at the edge
  int          smp_n = 0;
  int          wr_seen = 0;
  int          err_total = 0;
  int          n_compared = 0;
  acp_if link ();
  always #2 ref_clk = ~ref_clk;
  acp_host acp_host_inst (.I_REF_CLK(ref_clk), .I_RSTN(rstn),
    .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr),
    .I_AVS_WRITEDATA(av_wdata), .O_AVS_READDATA(av_rdata),
    .O_AVS_WAITREQUEST(av_wait), .link(link));
  acp_device acp_device_inst (.I_REF_CLK(ref_clk), .I_RSTN(rstn),
    .link(link), .O_ACTIVE(act), .O_AUDIO_OE(aud_oe), .O_WR_VALID(wr_vld),
    .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data));
  acp_monitor acp_monitor_inst (.I_REF_CLK(ref_clk), .I_RSTN(rstn),
    .sclk(link.sclk), .host_mosi(link.host_mosi),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .latch_or_address_select(link.latch_or_address_select),
    .format_select(link.format_select),
    .serial_data_line(link.serial_data_line));
  // frame recorder restarts on a start or a falling chip select
  always @(negedge link.serial_data_line)
    if (link.sclk && !link.format_select)
      wire_n = 0;
  always @(negedge link.latch_or_address_select)
    if (link.format_select)
      wire_n = 0;
  always @(posedge link.sclk)
    if (wire_n < 27 && !(link.format_select &&
        link.latch_or_address_select)) begin
      wire_bits = {wire_bits[25:0], link.serial_data_line};
      wire_n = wire_n + 1;
    end
  // bus answer captured with the values standing at each rising edge
  always @(posedge ref_clk) begin
    smp_wait <= av_wait;
    smp_rdata <= av_rdata;
    smp_n <= smp_n + 1;
  end
  // keep the last committed word; the pulse lasts one cycle only
  always @(posedge ref_clk)
    if (wr_vld === 1'b1) begin
      wr_seen <= wr_seen + 1;
      cap_addr <= wr_addr;
      cap_data <= wr_data;
    end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until an edge samples waitrequest low; data taken there
  task automatic av_xfer(input logic rd, input logic [3:0] a,
                         input logic [31:0] wd, output logic [31:0] q);
    @(posedge ref_clk);
    av_addr <= a;
    av_wdata <= wd;
    av_rd <= rd;
    av_wr <= !rd;
    do begin
      @(posedge ref_clk);
      @(smp_n);
    end while (smp_wait !== 1'b0);
    q = smp_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic send_word(input logic fmt, input logic csel,
                           input logic [15:0] word);
    logic [31:0] st;
    int          n;
    int          seen0;
    seen0 = wr_seen;
    av_xfer(1'b0, HOFS_WORD, {16'h0000, word}, st);
    av_xfer(1'b0, HOFS_CTRL, {29'h0, csel, fmt, 1'b1}, st);
    n = 0;
    do begin
      av_xfer(1'b1, HOFS_STATUS, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    repeat (20) if (wr_seen == seen0) @(posedge ref_clk);
    chk(32'(wr_seen - seen0), 32'h1);
    chk({31'h0, st[HBIT_NACK]}, 32'h0);
    chk({16'h0, cap_addr, cap_data}, {16'h0, word});
    if (fmt)
      chk({16'h0, wire_bits[15:0]}, {16'h0, word});
    else
      chk({5'h0, wire_bits}, {5'h0, SLAVE_BASE, csel, 2'b00,
        word[15:8], 1'b0, word[7:0], 1'b0});
  endtask
  task automatic s_reset_state();
    logic [31:0] q;
    chk({30'h0, act, aud_oe}, 32'h0);
    av_xfer(1'b1, 4'hc, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic s_two_wire();
    send_word(1'b0, 1'b0, 16'h0bff);
    send_word(1'b0, 1'b1, 16'hfe00);
  endtask
  task automatic s_three_wire();
    send_word(1'b1, 1'b0, 16'ha5c3);
    send_word(1'b1, 1'b1, 16'h5a3c);
  endtask
  // other registers must leave the activate state alone
  task automatic s_activate(input logic fmt);
    send_word(fmt, 1'b0, {REG_ACTIVE, 9'h001});
    chk({30'h0, act, aud_oe}, 32'h3);
    send_word(fmt, 1'b1, {7'h08, 9'h000});
    chk({30'h0, act, aud_oe}, 32'h3);
    send_word(fmt, 1'b0, {REG_ACTIVE, 9'h1fe});
    chk({30'h0, act, aud_oe}, 32'h0);
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    s_reset_state();
    s_two_wire();
    s_three_wire();
    s_activate(1'b0);
    s_activate(1'b1);
    wrap_up();
  end
  // ten transfers need about 14 us; allow generous slack
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule

// [hw/acp_device.sv]
// acp_device: write-only control port of the audio ADC
// assumes link pins are asynchronous; host keeps its side of the protocol
//
// Overview of operation
// - strap low 2-wire, high 3-wire
// - 3-wire: data clocked in, chip select commits
// - word: seven address bits, nine data bits
// - commit on chip select rising edge only
// - 2-wire address 0011010 or 0011011 by pin
// - address is six base bits plus pin
// - start: data falls while clock high
// - eight bits msb first: address, direction
// - matching write address gets acknowledge low
// - read requests are never acknowledged
// - address mismatch: idle until next start
// - first byte bits 15..8, acknowledged
// - second byte bits 7..0, acknowledged
// - stop: data rises while clock high
// - unexpected start or stop abandons transfer
// - full sequence per write, then idle
// - inactive: audio outputs tristated, pulled down
// - register 9 bit 0 activates interface
// - host toggles activate around changes
`timescale 1ns/1ns
module acp_device
  import acp_pkg::*;
(
  input  wire logic        I_REF_CLK,   // 250 MHz
  input  wire logic        I_RSTN,      // sync reset, active low
  acp_if.device            link,        // serial control link
  output logic             O_ACTIVE,    // audio interface enabled
  output logic             O_AUDIO_OE,  // audio outputs driven
  output logic             O_WR_VALID,  // one-cycle register write
  output logic [ADDR_W-1:0] O_WR_ADDR,  // written register address
  output logic [DATA_W-1:0] O_WR_DATA   // written register data
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum {ST_IDLE, ST_SHIFT, ST_ACK, ST_IGNORE} acp_st_type;
  typedef struct packed {
    logic [1:0]        s_scl, s_sda, s_cs, s_fmt;  // synchronisers
    logic              scl, sda, cs, fmt;          // settled levels
    acp_st_type        st;
    logic [4:0]        bitn;
    logic [1:0]        phase;   // 0 address, 1 byte hi, 2 byte lo
    logic [BYTE_W-1:0] sh;
    logic [WORD_W-1:0] word;
    logic              ack_oe;
    logic              active;
    logic              wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
  } acp_dev_type;
  acp_dev_type r, next_r;

  logic scl_rise, scl_fall, sda_rise, sda_fall, cs_rise, fmt3, start_c;
  logic stop_c;
  logic [6:0] my_addr;

  // ************************************************************
  // next state
  // ************************************************************
  // levels are only read after the second flop of each synchroniser
  always_comb begin
    next_r = r;
    next_r.wr_valid = 1'b0;
    next_r.s_scl = {r.s_scl[0], link.sclk};
    next_r.s_sda = {r.s_sda[0], link.serial_data_line};
    next_r.s_cs  = {r.s_cs[0], link.latch_or_address_select};
    next_r.s_fmt = {r.s_fmt[0], link.format_select};
    next_r.scl = r.s_scl[1];
    next_r.sda = r.s_sda[1];
    next_r.cs  = r.s_cs[1];
    next_r.fmt = r.s_fmt[1];
    scl_rise = r.s_scl[1] && !r.scl;
    scl_fall = !r.s_scl[1] && r.scl;
    sda_rise = r.s_sda[1] && !r.sda;
    sda_fall = !r.s_sda[1] && r.sda;
    cs_rise  = r.s_cs[1] && !r.cs;
    fmt3     = (r.s_fmt[1] == FMT_3W[0]);
    my_addr  = {SLAVE_BASE, r.cs};
    start_c  = sda_fall && r.scl && r.s_scl[1];
    stop_c   = sda_rise && r.scl && r.s_scl[1];
    if (fmt3) begin
      next_r.st = ST_IDLE;
      next_r.ack_oe = 1'b0;
      // shift while selected; the last 16 bits are kept
      if (scl_rise && !r.cs)
        next_r.word = {r.word[WORD_W-2:0], r.sda};
      // a strap change lifts the pin from address bit to chip select;
      // that rise is not a latch edge, so the format must have settled
      if (cs_rise && r.fmt == FMT_3W[0]) begin
        next_r.wr_valid = 1'b1;
        next_r.wr_addr  = r.word[WORD_W-1:ADDR_LSB];
        next_r.wr_data  = r.word[DATA_W-1:0];
      end
    end else if (start_c) begin
      // a start anywhere restarts address reception
      next_r.st = ST_SHIFT;
      next_r.bitn = BIT_ZERO;
      next_r.phase = 2'h0;
      next_r.ack_oe = 1'b0;
    end else if (stop_c) begin
      next_r.st = ST_IDLE;
      next_r.ack_oe = 1'b0;
    end else begin
      case (r.st)
        ST_SHIFT: begin
          if (scl_rise) begin
            next_r.sh = {r.sh[BYTE_W-2:0], r.sda};
            next_r.bitn = r.bitn + 5'h01;
          end
          // drive ack from the falling edge after the eighth bit
          if (scl_fall && r.bitn == LAST_BIT + 5'h01) begin
            next_r.bitn = BIT_ZERO;
            if (r.phase == 2'h0) begin
              if (r.sh == {my_addr, 1'b0}) begin
                next_r.st = ST_ACK;
                next_r.ack_oe = 1'b1;
              end else
                next_r.st = ST_IGNORE;
            end else begin
              next_r.st = ST_ACK;
              next_r.ack_oe = 1'b1;
              if (r.phase == 2'h1)
                next_r.word[WORD_W-1:BYTE_W] = r.sh;
              else
                next_r.word[BYTE_W-1:0] = r.sh;
            end
          end
        end
        ST_ACK: begin
          // release after the acknowledge clock pulse falls
          if (scl_fall) begin
            next_r.ack_oe = 1'b0;
            if (r.phase == 2'h2) begin
              next_r.st = ST_IDLE;
              next_r.wr_valid = 1'b1;
              next_r.wr_addr = r.word[WORD_W-1:ADDR_LSB];
              next_r.wr_data = r.word[DATA_W-1:0];
            end else begin
              next_r.st = ST_SHIFT;
              next_r.phase = r.phase + 2'h1;
            end
          end
        end
        ST_IGNORE: next_r.st = ST_IGNORE;  // left by a start, or by a stop into ST_IDLE
        ST_IDLE:   next_r.st = ST_IDLE;
        default:   next_r.st = ST_IDLE;
      endcase
    end
    // interface activate register, one bit of state kept
    if (next_r.wr_valid && next_r.wr_addr == REG_ACTIVE)
      next_r.active = next_r.wr_data[ACTIVE_BIT];
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.scl <= 1'b1;
      r.sda <= 1'b1;
      r.cs <= 1'b1;
      r.s_scl <= 2'h3;
      r.s_sda <= 2'h3;
      r.s_cs <= 2'h3;
      r.active <= ACTIVE_RST[ACTIVE_BIT];
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // acknowledge pulls low only; open drain, never drives high
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = r.ack_oe;
  assign O_ACTIVE   = r.active;
  assign O_AUDIO_OE = r.active;  // low keeps audio pins tristated
  assign O_WR_VALID = r.wr_valid;
  assign O_WR_ADDR  = r.wr_addr;
  assign O_WR_DATA  = r.wr_data;
endmodule

// [hw/acp_host.sv]
// acp_host: host controller that writes one 16-bit word per command
// assumes an Avalon-MM master with waitrequest drives its registers
`timescale 1ns/1ns
module acp_host
  import acp_pkg::*;
(
  input  wire logic        I_REF_CLK,          // 250 MHz
  input  wire logic        I_RSTN,             // sync reset, active low
  input  wire logic [3:0]  I_AVS_ADDRESS,      // byte address
  input  wire logic        I_AVS_READ,         // read strobe
  input  wire logic        I_AVS_WRITE,        // write strobe
  input  wire logic [31:0] I_AVS_WRITEDATA,    // write data
  output logic [31:0]      O_AVS_READDATA,     // read data
  output logic             O_AVS_WAITREQUEST,  // stall
  acp_if.host              link                // serial control link
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum {H_IDLE, H_CSLO, H_BIT, H_CSHI, H_START, H_ACK,
                H_STOP, H_DONE} acp_hst_type;
  typedef struct packed {
    acp_hst_type       st;
    logic [7:0]        cnt;
    logic [4:0]        bitn;
    logic [1:0]        phase;
    logic              sclk, sda_low, mosi, cs, fmt, csel;
    logic [WORD_W-1:0] word;
    logic [BYTE_W-1:0] sh;
    logic              nack;
    logic [1:0]        s_sda;
    logic              ack_seen;
    logic              rvalid;
    logic [31:0]       rdata;
  } acp_host_type;
  acp_host_type r, next_r;
  logic busy, tick;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.s_sda = {r.s_sda[0], link.serial_data_line};
    next_r.rvalid = 1'b0;
    busy = (r.st != H_IDLE);
    tick = (r.cnt == CNT_ZERO);
    next_r.cnt = tick ? HALF_CNT : r.cnt - 8'h01;
    // bus slave: reads answer next cycle; writes taken at once, dropped while busy
    if (I_AVS_READ && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      case (I_AVS_ADDRESS)
        HOFS_WORD:   next_r.rdata = {16'h0000, r.word};
        HOFS_STATUS: next_r.rdata = {30'h0, r.nack, busy};
        HOFS_CTRL:   next_r.rdata = {29'h0, r.csel, r.fmt, 1'b0};
        default:     next_r.rdata = 32'h0;
      endcase
    end
    if (I_AVS_WRITE && I_AVS_ADDRESS == HOFS_WORD && !busy)
      next_r.word = I_AVS_WRITEDATA[WORD_W-1:0];
    if (I_AVS_WRITE && I_AVS_ADDRESS == HOFS_CTRL && !busy) begin
      next_r.fmt  = I_AVS_WRITEDATA[HBIT_FMT];
      next_r.csel = I_AVS_WRITEDATA[HBIT_CSEL];
      if (I_AVS_WRITEDATA[HBIT_GO]) begin
        next_r.st = I_AVS_WRITEDATA[HBIT_FMT] ? H_CSLO : H_START;
        next_r.nack = 1'b0;
        next_r.bitn = BIT_ZERO;
        next_r.phase = 2'h0;
        next_r.cnt = HALF_CNT;
        next_r.sh = {SLAVE_BASE, I_AVS_WRITEDATA[HBIT_CSEL], 1'b0};
      end
    end
    if (tick) begin
      case (r.st)
        H_CSLO: begin
          next_r.cs = 1'b0;
          next_r.st = H_BIT;
        end
        H_BIT: begin
          // data changes on low clock, sampled on the rise
          if (r.fmt) begin
            // data moves only on the fall so it is steady at the rise
            if (!r.sclk) begin
              next_r.sclk = 1'b1;
              if (r.bitn == LAST_WBIT) next_r.st = H_CSHI;
              else next_r.bitn = r.bitn + 5'h01;
            end else begin
              next_r.sclk = 1'b0;
              next_r.mosi = r.word[LAST_WBIT[3:0] - r.bitn[3:0]];
            end
          end else begin
            if (!r.sclk) begin
              next_r.sclk = 1'b1;
            end else begin
              next_r.sclk = 1'b0;
              if (r.bitn == LAST_BIT) begin
                next_r.st = H_ACK;
                next_r.sda_low = 1'b0;
              end else begin
                next_r.bitn = r.bitn + 5'h01;
                next_r.sda_low = !r.sh[LAST_BIT[2:0] - r.bitn[2:0] - 3'h1];
              end
            end
          end
        end
        H_CSHI: begin
          next_r.cs = 1'b1;
          next_r.st = H_DONE;
        end
        H_START: begin
          // start with clock high, then lower clock with the first bit
          if (!r.sda_low) next_r.sda_low = 1'b1;
          else begin
            next_r.sclk = 1'b0;
            next_r.sda_low = !r.sh[LAST_BIT[2:0]];
            next_r.st = H_BIT;
          end
        end
        H_ACK: begin
          if (!r.sclk) begin
            next_r.sclk = 1'b1;
            next_r.ack_seen = !r.s_sda[1];
          end else begin
            next_r.sclk = 1'b0;
            next_r.bitn = BIT_ZERO;
            if (!r.ack_seen || r.phase == 2'h2) begin
              next_r.nack = !r.ack_seen;
              next_r.sda_low = 1'b1;
              next_r.st = H_STOP;
            end else begin
              next_r.phase = r.phase + 2'h1;
              next_r.sh = (r.phase == 2'h0) ? r.word[WORD_W-1:BYTE_W]
                                            : r.word[BYTE_W-1:0];
              next_r.sda_low = (r.phase == 2'h0) ? !r.word[WORD_W-1]
                                                 : !r.word[BYTE_W-1];
              next_r.st = H_BIT;
            end
          end
        end
        H_STOP: begin
          if (!r.sclk) next_r.sclk = 1'b1;
          else begin
            next_r.sda_low = 1'b0;
            next_r.st = H_DONE;
          end
        end
        H_DONE:  next_r.st = H_IDLE;
        H_IDLE:  next_r.st = H_IDLE;
        default: next_r.st = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      r <= '0;
      r.st <= H_IDLE;
      r.sclk <= 1'b1;
      r.cs <= 1'b1;
      r.s_sda <= 2'h3;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // writes never stall; reads stall one cycle for registered data
  assign O_AVS_WAITREQUEST = I_AVS_READ && !r.rvalid;
  assign O_AVS_READDATA = r.rdata;
  assign link.sclk = r.sclk;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = r.sda_low;
  assign link.host_mosi = r.mosi;
  assign link.latch_or_address_select = r.fmt ? r.cs : r.csel;
  assign link.format_select = r.fmt;
endmodule

// [hw/acp_if.sv]
// acp_if: serial control link between host controller and device
// assumes an open-drain data line pulled up; clock driven by host
`timescale 1ns/1ns
interface acp_if;
  logic sclk;                     // serial clock from host
  logic host_sda_o;               // host drives data low when oe
  logic host_sda_oe;
  logic dev_sda_o;                // device acknowledge drive
  logic dev_sda_oe;
  logic host_mosi;                // 3-wire data, push-pull
  logic latch_or_address_select;  // chip select / address bit
  logic format_select;            // strap: 0 2-wire, 1 3-wire
  logic serial_data_line;         // resolved line level
  // open drain with pull-up in 2-wire, host push-pull in 3-wire
  assign serial_data_line = format_select ? host_mosi :
    !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output sclk, host_sda_o, host_sda_oe, host_mosi,
                output latch_or_address_select, format_select,
                input serial_data_line);
  modport device (input sclk, serial_data_line, format_select,
                  input latch_or_address_select,
                  output dev_sda_o, dev_sda_oe);
endinterface

// [hw/acp_pkg.sv]
// acp_pkg: shared constants for the audio codec control port
// assumes both ends, the monitor and the bench import it
package acp_pkg;
  localparam int WORD_W        = 16;  // address plus data
  localparam int ADDR_W        = 7;   // register address bits
  localparam int DATA_W        = 9;   // register data bits
  localparam int BYTE_W        = 8;   // bits per byte on the 2-wire bus
  localparam int ADDR_LSB      = 9;   // position of the address field
  localparam logic [5:0] SLAVE_BASE = 6'h0d;  // fixed upper six bits
  localparam logic [6:0] REG_ACTIVE = 7'h09;  // interface activate reg
  localparam int ACTIVE_BIT    = 0;   // activate bit inside its data
  localparam logic [8:0] ACTIVE_RST = 9'h000;
  localparam logic [1:0] FMT_2W = 2'h0;        // strap low
  localparam logic [1:0] FMT_3W = 2'h1;        // strap high
  // host side: register offsets on its Avalon-MM port (byte addresses)
  localparam logic [3:0] HOFS_CTRL   = 4'h0;   // w/r: go bit, format, csel; go reads 0
  localparam logic [3:0] HOFS_WORD   = 4'h4;   // w/r: 16-bit word
  localparam logic [3:0] HOFS_STATUS = 4'h8;   // r: busy, nack
  localparam int HBIT_GO   = 0;
  localparam int HBIT_FMT  = 1;
  localparam int HBIT_CSEL = 2;
  localparam int HBIT_NACK = 1;
  // link clock timing from the host clock
  localparam int CLK_NS      = 4;    // 250 MHz
  localparam int LINK_HALF_NS = 24;  // least half period of serial clock
  localparam int HALF_CYC =
    (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;  // rounded up
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [4:0] BIT_ZERO = 5'h00;
  localparam logic [4:0] LAST_BIT = 5'h07;
  localparam logic [4:0] LAST_WBIT = 5'h0f;
endpackage
